// file: hdl/crb_regs.svh
`ifndef CRB_REGS_SVH
`define CRB_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CRB_OFF_PC      8'h00
`define CRB_OFF_ACC     8'h04
`define CRB_OFF_TMP     8'h08
`define CRB_OFF_IDX     8'h0C
`define CRB_OFF_EP      8'h10
`define CRB_OFF_SP      8'h14
`define CRB_OFF_PSW     8'h18
`define CRB_OFF_OP      8'h1C
`define CRB_OFF_GSEL    8'h20
`define CRB_OFF_GDATA   8'h24
`define CRB_OFF_BANK    8'h28
`define CRB_OFF_REGION  8'h2C

// ----------------------------------------
// condition byte fields
// ----------------------------------------
`define CRB_CC_H        7
`define CRB_CC_I        6
`define CRB_CC_IL_HI    5
`define CRB_CC_IL_LO    4
`define CRB_CC_N        3
`define CRB_CC_Z        2
`define CRB_CC_V        1
`define CRB_CC_C        0

// ----------------------------------------
// reset values and memory map
// ----------------------------------------
`define CRB_PSW_RST     16'h0030
`define CRB_W16_RST     16'h0000
`define CRB_EXT_LO      16'h0180
`define CRB_EXT_HI      16'h01FF

`endif

// file: hdl/crb_pkg.sv
package crb_pkg;

  typedef enum logic [2:0] {
    OP_ADD  = 3'h0,
    OP_ADDC = 3'h1,
    OP_SUB  = 3'h2,
    OP_SHL  = 3'h3,
    OP_SHR  = 3'h4,
    OP_DAA  = 3'h5,
    OP_ADDW = 3'h6
  } crb_op_e;

  typedef enum logic [1:0] {
    REG_IO   = 2'h0,
    REG_DATA = 2'h1,
    REG_PROG = 2'h2
  } crb_region_e;

endpackage

// file: hdl/crb_flag_alu.sv
`timescale 1ns/1ps
module crb_flag_alu
  import crb_pkg::*;
(
  input  wire crb_op_e     op,
  input  wire logic [15:0] acc,
  input  wire logic [15:0] tmp,
  input  wire logic        cin,
  input  wire logic        hin,
  output logic      [15:0] res,
  output logic             n,
  output logic             z,
  output logic             v,
  output logic             c,
  output logic             h
);

  always_comb begin
    logic [8:0]  s9;
    logic [4:0]  s5;
    logic [16:0] s17;
    logic [7:0]  adj;
    logic        cx;
    s9  = '0;
    s5  = '0;
    s17 = '0;
    adj = 8'h00;
    cx  = (op == OP_ADDC) & cin;
    res = acc;
    v   = 1'b0;
    c   = cin;
    h   = hin;
    unique case (op)
      OP_ADD, OP_ADDC: begin
        s9  = {1'b0, acc[7:0]} + {1'b0, tmp[7:0]} + {8'h00, cx};
        s5  = {1'b0, acc[3:0]} + {1'b0, tmp[3:0]} + {4'h0, cx};
        res = {acc[15:8], s9[7:0]};
        c   = s9[8];
        h   = s5[4];
        v   = (acc[7] == tmp[7]) && (s9[7] != acc[7]);
      end
      OP_SUB: begin
        s9  = {1'b0, acc[7:0]} - {1'b0, tmp[7:0]};
        s5  = {1'b0, acc[3:0]} - {1'b0, tmp[3:0]};
        res = {acc[15:8], s9[7:0]};
        c   = s9[8];
        h   = s5[4];
        v   = (acc[7] != tmp[7]) && (s9[7] != acc[7]);
      end
      OP_SHL: begin
        res = {acc[15:8], acc[6:0], cin};
        c   = acc[7];
      end
      OP_SHR: begin
        res = {acc[15:8], cin, acc[7:1]};
        c   = acc[0];
      end
      OP_DAA: begin
        if (hin || (acc[3:0] > 4'h9)) begin
          adj[3:0] = 4'h6;
        end
        if (cin || (acc[7:0] > 8'h99)) begin
          adj[7:4] = 4'h6;
        end
        s9  = {1'b0, acc[7:0]} + {1'b0, adj};
        s5  = {1'b0, acc[3:0]} + {1'b0, adj[3:0]};
        res = {acc[15:8], s9[7:0]};
        c   = cin | (acc[7:0] > 8'h99);
        h   = s5[4];
      end
      OP_ADDW: begin
        s17 = {1'b0, acc} + {1'b0, tmp};
        s5  = {1'b0, acc[3:0]} + {1'b0, tmp[3:0]};
        res = s17[15:0];
        c   = s17[16];
        h   = s5[4];
        v   = (acc[15] == tmp[15]) && (s17[15] != acc[15]);
      end
      default: begin
        res = acc;
      end
    endcase
    // byte operations judge only the low byte
    n = (op == OP_ADDW) ? res[15] : res[7];
    z = (op == OP_ADDW) ? (res == 16'h0000) : (res[7:0] == 8'h00);
  end

endmodule

// file: hdl/crb_core_regs.sv
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "crb_regs.svh"
// Behaviour
// - a 16-bit instruction pointer locates the next instruction to fetch
// - 16-bit accumulator takes results; byte operations touch only its low byte
// - 16-bit temporary accumulator is the second operand; bytes use low byte
// - 16-bit index register, extra pointer and stack pointer are held
// - status word: upper byte is bank pointer, lower byte is condition byte
// - half-carry follows carry or borrow between bits 3 and 4
// - interrupt enable permits interrupts when 1; reset clears it
// - interrupt taken only when request level beats current level; 11 is lowest
// - negative flag copies result msb
// - zero flag set exactly when result is zero
// - overflow flag marks two's-complement overflow
// - carry flag marks carry or borrow out of bit 7, out of bit 15 for the word add
// - shifts load carry with the bit shifted out
// - 8-bit general registers, eight per bank, up to 32 banks
// - general register accesses use the bank chosen by the bank pointer
// - small variant: upper 16 banks need external memory at 0180-01FF
// - one 64 KB space: I/O lowest, data above, program with vectors at top
module crb_core_regs
  import crb_pkg::*;
#(
  parameter logic [5:0]  INT_BANKS  = 6'd32,
  parameter logic [15:0] BANK_BASE  = 16'h0100,
  parameter int          BANK_SHIFT = 3,
  parameter logic [15:0] IO_TOP     = 16'h007F,
  parameter logic [15:0] DATA_TOP   = 16'h7FFF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        irq_req,
  input  wire logic [1:0]  irq_level,
  input  wire logic        ext_bank_en,
  output logic             irq_take,
  output logic             ie_flag
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [15:0] pc_ff,  nxt_pc;
  logic [15:0] acc_ff, nxt_acc;
  logic [15:0] tmp_ff, nxt_tmp;
  logic [15:0] idx_ff, nxt_idx;
  logic [15:0] ep_ff,  nxt_ep;
  logic [15:0] sp_ff,  nxt_sp;
  logic [15:0] psw_ff, nxt_psw;
  logic [2:0]  op_ff,  nxt_op;
  logic [2:0]  gsel_ff, nxt_gsel;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready;
  logic        pslverr_ff, nxt_pslverr;
  logic        take_ff, nxt_take;
  logic [7:0]  gpr_mem [0:255];

  logic        setup;
  logic        access;
  logic        wr_go;
  logic        op_go;
  logic        gpr_wr;
  logic        mapped;
  logic        bank_ok;
  logic [4:0]  bank;
  logic [7:0]  gaddr;
  logic [15:0] bank_addr;
  crb_region_e region;
  crb_op_e     alu_op;
  logic [15:0] alu_res;
  logic        fn, fz, fv, fc, fh;

  // ----------------------------------------
  // bank address and region decode
  // ----------------------------------------
  // conversion kept behind parameters so another map can be dropped in
  function automatic logic [15:0] bank_base(input logic [4:0] rp);
    return BANK_BASE + 16'({11'h000, rp} << BANK_SHIFT);
  endfunction

  function automatic crb_region_e region_of(input logic [15:0] a);
    if (a <= IO_TOP) begin
      return REG_IO;
    end else if (a <= DATA_TOP) begin
      return REG_DATA;
    end
    return REG_PROG;
  endfunction

  assign bank      = psw_ff[12:8];
  assign bank_addr = bank_base(bank);
  assign region    = region_of(ep_ff);
  assign gaddr     = {bank, gsel_ff};
  // banks beyond the internal ones answer only when external ram is decoded
  assign bank_ok   = ({1'b0, bank} < INT_BANKS) ||
                     (ext_bank_en && (bank_addr >= `CRB_EXT_LO) &&
                      (bank_addr <= `CRB_EXT_HI));

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign setup  = psel & ~penable;
  assign access = psel & penable & pready_ff;
  assign wr_go  = access & pwrite & ~pslverr_ff;
  assign op_go  = wr_go & (paddr == `CRB_OFF_OP);
  assign gpr_wr = wr_go & (paddr == `CRB_OFF_GDATA);
  assign alu_op = crb_op_e'(pwdata[2:0]);

  always_comb begin
    unique case (paddr)
      `CRB_OFF_PC, `CRB_OFF_ACC, `CRB_OFF_TMP, `CRB_OFF_IDX,
      `CRB_OFF_EP, `CRB_OFF_SP, `CRB_OFF_PSW, `CRB_OFF_OP,
      `CRB_OFF_GSEL, `CRB_OFF_BANK, `CRB_OFF_REGION: mapped = 1'b1;
      `CRB_OFF_GDATA: mapped = bank_ok;
      default: mapped = 1'b0;
    endcase
  end

  crb_flag_alu u_alu (
    .op  (alu_op),
    .acc (acc_ff),
    .tmp (tmp_ff),
    .cin (psw_ff[`CRB_CC_C]),
    .hin (psw_ff[`CRB_CC_H]),
    .res (alu_res),
    .n   (fn),
    .z   (fz),
    .v   (fv),
    .c   (fc),
    .h   (fh)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_pc      = pc_ff;
    nxt_acc     = acc_ff;
    nxt_tmp     = tmp_ff;
    nxt_idx     = idx_ff;
    nxt_ep      = ep_ff;
    nxt_sp      = sp_ff;
    nxt_psw     = psw_ff;
    nxt_op      = op_ff;
    nxt_gsel    = gsel_ff;
    nxt_pready  = setup;
    nxt_pslverr = setup & ~mapped;
    nxt_prdata  = 32'h0000_0000;
    // read data is captured in setup so the answer comes from a flop
    if (setup && !pwrite && mapped) begin
      unique case (paddr)
        `CRB_OFF_PC:     nxt_prdata = {16'h0000, pc_ff};
        `CRB_OFF_ACC:    nxt_prdata = {16'h0000, acc_ff};
        `CRB_OFF_TMP:    nxt_prdata = {16'h0000, tmp_ff};
        `CRB_OFF_IDX:    nxt_prdata = {16'h0000, idx_ff};
        `CRB_OFF_EP:     nxt_prdata = {16'h0000, ep_ff};
        `CRB_OFF_SP:     nxt_prdata = {16'h0000, sp_ff};
        `CRB_OFF_PSW:    nxt_prdata = {16'h0000, psw_ff};
        `CRB_OFF_OP:     nxt_prdata = {29'h0, op_ff};
        `CRB_OFF_GSEL:   nxt_prdata = {29'h0, gsel_ff};
        `CRB_OFF_GDATA:  nxt_prdata = {24'h00_0000, gpr_mem[gaddr]};
        `CRB_OFF_BANK:   nxt_prdata = {16'h0000, bank_addr};
        `CRB_OFF_REGION: nxt_prdata = {30'h0, region};
        default:         nxt_prdata = 32'h0000_0000;
      endcase
    end
    if (wr_go) begin
      unique case (paddr)
        `CRB_OFF_PC:   nxt_pc   = pwdata[15:0];
        `CRB_OFF_ACC:  nxt_acc  = pwdata[15:0];
        `CRB_OFF_TMP:  nxt_tmp  = pwdata[15:0];
        `CRB_OFF_IDX:  nxt_idx  = pwdata[15:0];
        `CRB_OFF_EP:   nxt_ep   = pwdata[15:0];
        `CRB_OFF_SP:   nxt_sp   = pwdata[15:0];
        `CRB_OFF_PSW:  nxt_psw  = {3'b000, pwdata[12:0]};
        `CRB_OFF_GSEL: nxt_gsel = pwdata[2:0];
        default: ;
      endcase
    end
    // an operation write with a code other than 7 executes one instruction on acc and tmp
    if (op_go && (pwdata[2:0] != 3'h7)) begin
      nxt_op                = pwdata[2:0];
      nxt_acc               = alu_res;
      nxt_pc                = pc_ff + 16'h0001;
      nxt_psw[`CRB_CC_N]    = fn;
      nxt_psw[`CRB_CC_Z]    = fz;
      nxt_psw[`CRB_CC_V]    = fv;
      nxt_psw[`CRB_CC_C]    = fc;
      nxt_psw[`CRB_CC_H]    = fh;
    end
    // level 0 is highest; current level 0 therefore blocks all requests
    nxt_take = irq_req && psw_ff[`CRB_CC_I] &&
               (irq_level < psw_ff[`CRB_CC_IL_HI:`CRB_CC_IL_LO]);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_ff      <= `CRB_W16_RST;
      acc_ff     <= `CRB_W16_RST;
      tmp_ff     <= `CRB_W16_RST;
      idx_ff     <= `CRB_W16_RST;
      ep_ff      <= `CRB_W16_RST;
      sp_ff      <= `CRB_W16_RST;
      psw_ff     <= `CRB_PSW_RST;
      op_ff      <= 3'h0;
      gsel_ff    <= 3'h0;
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      take_ff    <= 1'b0;
    end else begin
      pc_ff      <= nxt_pc;
      acc_ff     <= nxt_acc;
      tmp_ff     <= nxt_tmp;
      idx_ff     <= nxt_idx;
      ep_ff      <= nxt_ep;
      sp_ff      <= nxt_sp;
      psw_ff     <= nxt_psw;
      op_ff      <= nxt_op;
      gsel_ff    <= nxt_gsel;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      take_ff    <= nxt_take;
    end
  end

  // no reset on the bank memory: software is expected to load it
  always_ff @(posedge pclk) begin
    if (gpr_wr) begin
      gpr_mem[gaddr] <= pwdata[7:0];
    end
  end

  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign irq_take = take_ff;
  assign ie_flag  = psw_ff[`CRB_CC_I];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  ie_reset_a: assert property (@(posedge pclk) $rose(presetn) |-> !psw_ff[`CRB_CC_I])
    else $error("interrupt enable not clear after reset");

  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_take |-> $past(irq_req) && $past(psw_ff[`CRB_CC_I]) &&
                 ($past(irq_level) < $past(psw_ff[5:4])))
    else $error("interrupt taken without enable or priority");

  zero_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (op_go && alu_op != OP_ADDW && pwdata[2:0] != 3'h7) |=>
      (psw_ff[`CRB_CC_Z] == (acc_ff[7:0] == 8'h00)))
    else $error("zero flag disagrees with result");

  neg_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (op_go && alu_op != OP_ADDW && pwdata[2:0] != 3'h7) |=>
      (psw_ff[`CRB_CC_N] == acc_ff[7]))
    else $error("negative flag disagrees with result msb");

  add_carry_a: assert property (@(posedge pclk) disable iff (!presetn)
    (op_go && alu_op == OP_ADD) |=>
      (psw_ff[`CRB_CC_C] == (({1'b0, $past(acc_ff[7:0])} + {1'b0, $past(tmp_ff[7:0])}) > 9'h0FF)))
    else $error("carry flag wrong after add");

  half_carry_a: assert property (@(posedge pclk) disable iff (!presetn)
    (op_go && alu_op == OP_ADD) |=>
      (psw_ff[`CRB_CC_H] == (({1'b0, $past(acc_ff[3:0])} + {1'b0, $past(tmp_ff[3:0])}) > 5'h0F)))
    else $error("half carry wrong after add");

  shift_carry_a: assert property (@(posedge pclk) disable iff (!presetn)
    (op_go && alu_op == OP_SHL) |=> (psw_ff[`CRB_CC_C] == $past(acc_ff[7])))
    else $error("shift did not load carry with shifted bit");

  sub_ovf_a: assert property (@(posedge pclk) disable iff (!presetn)
    (op_go && alu_op == OP_SUB) |=> (psw_ff[`CRB_CC_V] ==
      (($past(acc_ff[7]) != $past(tmp_ff[7])) && (acc_ff[7] != $past(acc_ff[7])))))
    else $error("overflow flag wrong after subtract");

  byte_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (op_go && alu_op != OP_ADDW) |=> (acc_ff[15:8] == $past(acc_ff[15:8])))
    else $error("byte operation changed accumulator high byte");

  pc_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (op_go && pwdata[2:0] != 3'h7) |=> (pc_ff == $past(pc_ff) + 16'h0001))
    else $error("instruction pointer did not advance");

  bank_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && paddr == `CRB_OFF_GDATA && !bank_ok) |=> (pready && pslverr))
    else $error("unavailable bank not refused");

endmodule

// file: test/cpu_status_and_register_banks_bench.sv
`timescale 1ns/1ps
`include "crb_regs.svh"
module cpu_status_and_register_banks_bench
  import crb_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq_req;
  logic [1:0]  irq_level;
  logic        ext_bank_en;
  logic        irq_take;
  logic        ie_flag;
  int          n_fail;
  int          n_compared;
  int          cycles;
  logic [31:0] r;
  logic        e;
  logic [7:0]  wregs [6];
  logic [7:0]  rps [5];
  logic [15:0] eps [5];
  logic [1:0]  regn [5];

  // small variant: upper banks live in external memory
  crb_core_regs #(.INT_BANKS(6'd16)) u_crb_core_regs (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .irq_req     (irq_req),
    .irq_level   (irq_level),
    .ext_bank_en (ext_bank_en),
    .irq_take    (irq_take),
    .ie_flag     (ie_flag)
  );

  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // ceiling well above the several hundred cycles the tests need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic complete_run();
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // one apb transfer; waits for pready without assuming a latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      check("pready", 32'h1, 32'h0);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        y;
    apb(1'b1, a, d, x, y);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    logic [31:0] x;
    logic        y;
    apb(1'b0, a, 32'h0, x, y);
    check(nm, ex, x);
    check("pslverr", 32'h0, {31'h0, y});
  endtask

  // load operands and status, run one operation, compare results
  task automatic run_op(input logic [2:0] c, input logic [15:0] a, input logic [15:0] t,
                        input logic [15:0] p, input logic [15:0] ea,
                        input logic [15:0] ep, input logic cp);
    wr(`CRB_OFF_ACC, {16'h0, a});
    wr(`CRB_OFF_TMP, {16'h0, t});
    wr(`CRB_OFF_PSW, {16'h0, p});
    wr(`CRB_OFF_OP, {29'h0, c});
    rd_chk(`CRB_OFF_ACC, {16'h0, ea}, "acc");
    if (cp) begin
      rd_chk(`CRB_OFF_PSW, {16'h0, ep}, "psw");
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    n_fail = 0;
    n_compared = 0;
    cycles = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    irq_req = 1'b0;
    irq_level = 2'h0;
    ext_bank_en = 1'b1;
    wregs = '{`CRB_OFF_PC, `CRB_OFF_ACC, `CRB_OFF_TMP, `CRB_OFF_IDX, `CRB_OFF_EP, `CRB_OFF_SP};
    rps = '{8'h00, 8'h05, 8'h0F, 8'h10, 8'h1F};
    eps = '{16'h007F, 16'h0080, 16'h7FFF, 16'h8000, 16'hFFFF};
    regn = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    check("ie_flag", 32'h0, {31'h0, ie_flag});
    rd_chk(`CRB_OFF_PSW, 32'h0000_0030, "psw");
    for (int i = 0; i < 6; i++) begin
      rd_chk(wregs[i], 32'h0, "reg");
      wr(wregs[i], {16'hFFFF, 16'h1111 * 16'(i + 1)});
      rd_chk(wregs[i], {16'h0, 16'h1111 * 16'(i + 1)}, "reg");
    end
    wr(`CRB_OFF_PSW, 32'hFFFF_FFFF);
    rd_chk(`CRB_OFF_PSW, 32'h0000_1FFF, "psw");
    // arithmetic and shift flags; condition byte is H I IL1 IL0 N Z V C
    wr(`CRB_OFF_PC, 32'h0000_FFFA);
    run_op(OP_ADD, 16'h127F, 16'h0001, 16'h0030, 16'h1280, 16'h00BA, 1'b1);
    run_op(OP_ADD, 16'h00FF, 16'h0001, 16'h0030, 16'h0000, 16'h00B5, 1'b1);
    run_op(OP_SUB, 16'h0000, 16'h0001, 16'h0030, 16'h00FF, 16'h00B9, 1'b1);
    run_op(OP_SUB, 16'h0080, 16'h0001, 16'h0030, 16'h007F, 16'h00B2, 1'b1);
    run_op(OP_ADDC, 16'h0010, 16'h0020, 16'h0031, 16'h0031, 16'h0030, 1'b1);
    run_op(OP_SHL, 16'h5581, 16'h0000, 16'h0030, 16'h5502, 16'h0031, 1'b1);
    run_op(OP_SHR, 16'h0003, 16'h0000, 16'h0030, 16'h0001, 16'h0031, 1'b1);
    run_op(OP_DAA, 16'h000A, 16'h0000, 16'h0030, 16'h0010, 16'h00B0, 1'b1);
    run_op(OP_ADDW, 16'h00FF, 16'h0001, 16'h0030, 16'h0100, 16'h0000, 1'b0);
    run_op(3'h7, 16'h1234, 16'h0001, 16'h0030, 16'h1234, 16'h0030, 1'b1);
    rd_chk(`CRB_OFF_PC, 32'h0000_0003, "pc");
    // interrupt gating over every enable, level and request level
    for (int i = 0; i < 2; i++) begin
      for (int il = 0; il < 4; il++) begin
        for (int lv = 0; lv < 4; lv++) begin
          wr(`CRB_OFF_PSW, {24'h0, 1'b0, i[0], il[1:0], 4'h0});
          @(posedge pclk);
          irq_req <= 1'b1;
          irq_level <= lv[1:0];
          repeat (2) @(posedge pclk);
          check("irq_take", {31'h0, i[0] && lv < il}, {31'h0, irq_take});
          check("ie_flag", {31'h0, i[0]}, {31'h0, ie_flag});
          irq_req <= 1'b0;
        end
      end
    end
    // reset in mid-run must clear a set interrupt enable
    wr(`CRB_OFF_PSW, 32'h0000_0040);
    @(posedge pclk);
    check("ie_flag", 32'h1, {31'h0, ie_flag});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("ie_flag", 32'h0, {31'h0, ie_flag});
    presetn <= 1'b1;
    rd_chk(`CRB_OFF_PSW, 32'h0000_0030, "psw");
    rd_chk(`CRB_OFF_PC, 32'h0, "pc");
    // banks: base address and separate storage per bank pointer
    for (int i = 0; i < 5; i++) begin
      wr(`CRB_OFF_PSW, {16'h0, rps[i], 8'h30});
      rd_chk(`CRB_OFF_BANK, {16'h0, 16'h0100 + 16'(rps[i]) * 16'h8}, "bank");
      for (int s = 0; s < 8; s += 7) begin
        wr(`CRB_OFF_GSEL, s);
        wr(`CRB_OFF_GDATA, {24'hFFFFFF, rps[i] * 8'h8 + 8'(s) + 8'h40});
      end
    end
    for (int i = 0; i < 5; i++) begin
      wr(`CRB_OFF_PSW, {16'h0, rps[i], 8'h30});
      for (int s = 0; s < 8; s += 7) begin
        wr(`CRB_OFF_GSEL, s);
        rd_chk(`CRB_OFF_GDATA, {24'h0, rps[i] * 8'h8 + 8'(s) + 8'h40}, "gpr");
      end
    end
    // upper bank refused while no external memory is decoded
    @(posedge pclk);
    ext_bank_en <= 1'b0;
    wr(`CRB_OFF_PSW, 32'h0000_1030);
    wr(`CRB_OFF_GSEL, 32'h7);
    apb(1'b1, `CRB_OFF_GDATA, 32'h0000_00EE, r, e);
    check("gdata_wr_err", 32'h1, {31'h0, e});
    apb(1'b0, `CRB_OFF_GDATA, 32'h0, r, e);
    check("gdata_err", 32'h1, {31'h0, e});
    check("gdata_rd", 32'h0, r);
    @(posedge pclk);
    ext_bank_en <= 1'b1;
    rd_chk(`CRB_OFF_GDATA, 32'h0000_00C7, "gpr");
    // address regions seen by the extra pointer
    for (int i = 0; i < 5; i++) begin
      wr(`CRB_OFF_EP, {16'h0, eps[i]});
      rd_chk(`CRB_OFF_REGION, {30'h0, regn[i]}, "region");
    end
    apb(1'b1, 8'h30, 32'h1234_5678, r, e);
    check("unmapped_err", 32'h1, {31'h0, e});
    apb(1'b0, 8'h30, 32'h0, r, e);
    check("unmapped_err", 32'h1, {31'h0, e});
    check("unmapped_rd", 32'h0, r);
    complete_run();
  end
endmodule
